/* hw/stp_top.sv */
// Step translator and positioner with an AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - Codes 101/110 give one-coil full step, code 111 two-coil full step.
// R2 - Full step one gives 100/0 patterns; full step two gives 71 on both coils.
// R3 - Switching full-step modes moves the position half a column, forward or back.
// R4 - That half-column move happens at the next trigger, not at the write.
// R5 - The 7-bit translator position in thirty-second steps is readable.
// R6 - The readable position updates right after each accepted trigger.
// R7 - Effective direction is the direction pin XOR the polarity bit.
// R8 - Positive direction rotates the current vector counter-clockwise, position up.
// R9 - Motor enable cleared does not stop the positioner from stepping.
// R10 - The direction pin level is readable in the status register.
// R11 - A step pin rising edge or push bit moves one step.
// R12 - Writing the push bit steps once, then the bit clears itself.
// R13 - A pin edge and a push, properly separated, give two steps.
// R14 - The controller never changes mode or direction pins with a step edge.
// R15 - A new step mode takes effect only at the next trigger.
// R16 - Current codes map to milliamps; hold code n equals run code n-1.
// R17 - Reset puts the position at 001 0000.
// R18 - In hold mode triggers are ignored and the hold current applies.
// R19 - Polarity, mode and push written together step with the new settings.
// R20 - The position wraps modulo 128 both ways.
// R21 - Coarse modes step by their power-of-two increment on their own grid.
module stp_top
  import stp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic step_trigger_pin,
  input wire logic direction_pin,
  input wire logic run_hold_pin,
  input wire logic mode_pin_low,
  input wire logic mode_pin_high,
  output stp_pos_t translator_position,
  output stp_pct_t coil_x_pct,
  output stp_pct_t coil_y_pct,
  output logic [3:0] current_code,
  output logic [9:0] current_ma,
  output logic motor_drive_enable,
  output logic run_mode
);
`include "stp_defs.svh"

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
    return addr[7:2] == off[7:2];
  endfunction : addr_hit

  function automatic stp_pos_t step_size(input logic [2:0] mode);
    return (mode >= STP_FULL1A) ? `STP_FULL_PITCH : (7'h01 << mode); // see R21
  endfunction : step_size

  // The position moves to the next grid point of the mode, so a change of grid lands
  // on the neighbouring column and plain 7-bit arithmetic gives the wrap-around.
  function automatic stp_pos_t next_position(input stp_pos_t pos, input logic [2:0] mode,
                                             input logic fwd);
    stp_pos_t inc;
    stp_pos_t off;
    stp_pos_t mask;
    stp_pos_t q;
    inc = step_size(mode);
    off = (mode == STP_FULL2) ? `STP_FULL2_OFFSET : 7'h00; // see R1
    mask = inc - 7'h01;
    q = pos - off;
    if (fwd) begin
      q = (q & ~mask) + inc; // see R8
    end else if ((q & mask) == 7'h00) begin
      q = q - inc; // see R20
    end else begin
      q = q & ~mask; // see R3
    end
    return q + off;
  endfunction : next_position

  function automatic logic [9:0] run_ma(input logic [3:0] code);
    case (code)
      4'h0: return 10'h03B;
      4'h1: return 10'h047;
      4'h2: return 10'h054;
      4'h3: return 10'h064;
      4'h4: return 10'h077;
      4'h5: return 10'h08D;
      4'h6: return 10'h0A8;
      4'h7: return 10'h0C8;
      4'h8: return 10'h0EE;
      4'h9: return 10'h11B;
      4'hA: return 10'h150;
      4'hB: return 10'h190;
      4'hC: return 10'h1DC;
      4'hD: return 10'h236;
      4'hE: return 10'h2A1;
      default: return 10'h320;
    endcase
  endfunction : run_ma

  // Pins arrive without a clock, so each passes two flip-flops first.
  logic [4:0] pins_sync;
  logic step_sync;
  logic dir_sync;
  logic rh_sync;
  logic step_prev_reg;
  stp_sync #(.WIDTH(5)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({mode_pin_high, mode_pin_low, run_hold_pin, direction_pin, step_trigger_pin}),
    .sync_out(pins_sync)
  );
  assign step_sync = pins_sync[0];
  assign dir_sync = pins_sync[1];
  assign rh_sync = pins_sync[2];

  logic [7:0] ctrl_reg;
  logic [7:0] cur_reg;
  logic push_reg;
  logic push_next;
  logic [2:0] applied_mode_reg;
  stp_pos_t pos_reg;
  stp_pos_t pos_next;

  // AXI4-Lite slave.
  logic aw_take;
  logic w_take;
  logic do_write;
  logic ar_take;
  logic wr_ctrl;
  logic wr_cur;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_data;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign wr_ctrl = do_write & addr_hit(awaddr_reg, `STP_ADDR_CTRL) & wstrb_reg[0];
  assign wr_cur = do_write & addr_hit(awaddr_reg, `STP_ADDR_CURRENT) & wstrb_reg[0];
  assign wr_ok = addr_hit(awaddr_reg, `STP_ADDR_CTRL) | addr_hit(awaddr_reg, `STP_ADDR_CURRENT) |
                 addr_hit(awaddr_reg, `STP_ADDR_STATUS) |
                 addr_hit(awaddr_reg, `STP_ADDR_POSITION) | addr_hit(awaddr_reg, `STP_ADDR_COIL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `STP_RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (aw_take) begin
        s_axi_awready <= 1'b0;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `STP_RESP_OKAY : `STP_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  logic [2:0] sel_mode;
  logic eff_dir;
  logic pin_edge;
  logic trigger;
  logic step_fire;
  logic push_done;
  logic run_next;

  assign sel_mode = ctrl_reg[`STP_CTRL_PIN_MODE] ? {1'b0, pins_sync[4], pins_sync[3]} :
                    ctrl_reg[`STP_CTRL_MODE_MSB:`STP_CTRL_MODE_LSB];
  assign eff_dir = dir_sync ^ ctrl_reg[`STP_CTRL_DIR_POL]; // see R7
  assign pin_edge = step_sync & ~step_prev_reg;
  assign trigger = pin_edge | push_reg; // see R11
  // Motor enable is deliberately left out of this term. The live run state is used, so a
  // run/hold polarity written together with the push already governs that push.
  assign step_fire = trigger & run_next; // see R9, R18
  // A push that meets a pin edge waits one cycle, so neither trigger is lost.
  assign push_done = push_reg & ~pin_edge; // see R13
  assign push_next = (wr_ctrl & wdata_reg[`STP_CTRL_PUSH]) | (push_reg & ~push_done); // see R12
  assign pos_next = step_fire ? next_position(pos_reg, sel_mode, eff_dir) : pos_reg;

  assign rd_ok = addr_hit(s_axi_araddr, `STP_ADDR_CTRL) | addr_hit(s_axi_araddr, `STP_ADDR_CURRENT) |
                 addr_hit(s_axi_araddr, `STP_ADDR_STATUS) |
                 addr_hit(s_axi_araddr, `STP_ADDR_POSITION) | addr_hit(s_axi_araddr, `STP_ADDR_COIL);
  assign rd_data =
    addr_hit(s_axi_araddr, `STP_ADDR_CTRL) ? {24'h000000, ctrl_reg[7:6], push_reg, ctrl_reg[4:0]} :
    addr_hit(s_axi_araddr, `STP_ADDR_CURRENT) ? {24'h000000, cur_reg} :
    addr_hit(s_axi_araddr, `STP_ADDR_STATUS) ?
      {6'h00, current_ma, 9'h000, applied_mode_reg, eff_dir, run_mode, rh_sync, dir_sync} :
    addr_hit(s_axi_araddr, `STP_ADDR_POSITION) ? {25'h0000000, pos_reg} : // see R5
    addr_hit(s_axi_araddr, `STP_ADDR_COIL) ? {5'h00, coil_y_pct, 5'h00, coil_x_pct} :
    32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `STP_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data; // see R10
      s_axi_rresp <= rd_ok ? `STP_RESP_OKAY : `STP_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // Positioner state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `STP_CTRL_RESET;
      cur_reg <= `STP_CUR_RESET;
      push_reg <= 1'b0;
      step_prev_reg <= 1'b0;
      applied_mode_reg <= STP_MICRO32;
      pos_reg <= `STP_POS_RESET; // see R17
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata_reg[7:0]; // see R19
      end
      if (wr_cur) begin
        cur_reg <= wdata_reg[7:0];
      end
      push_reg <= push_next;
      step_prev_reg <= step_sync;
      pos_reg <= pos_next; // see R6, R4
      if (step_fire) begin
        applied_mode_reg <= sel_mode; // see R15
      end
    end
  end

  logic [3:0] code_next;
  logic [9:0] ma_next;
  assign run_next = rh_sync ^ ctrl_reg[`STP_CTRL_RH_POL];
  assign code_next = run_next ? cur_reg[`STP_CUR_RUN_MSB:`STP_CUR_RUN_LSB] :
                                cur_reg[`STP_CUR_HOLD_MSB:`STP_CUR_HOLD_LSB];
  assign ma_next = run_next ? run_ma(code_next) :
                   (code_next == 4'h0) ? 10'h000 : run_ma(code_next - 4'h1); // see R16

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_mode <= 1'b0;
      current_code <= 4'h0;
      current_ma <= 10'h000;
      motor_drive_enable <= 1'b0;
      translator_position <= `STP_POS_RESET;
    end else begin
      run_mode <= run_next;
      current_code <= code_next; // see R18
      current_ma <= ma_next;
      motor_drive_enable <= ctrl_reg[`STP_CTRL_MOTOR_DRIVE_ENABLE];
      translator_position <= pos_next;
    end
  end

  stp_coil_map u_coil (
    .aclk(aclk),
    .aresetn(aresetn),
    .position(pos_reg),
    .full2(applied_mode_reg == STP_FULL2),
    .coil_x_pct(coil_x_pct),
    .coil_y_pct(coil_y_pct)
  );

  property p_reset_position;
    @(posedge aclk) !aresetn |=> pos_reg == 7'h10;
  endproperty
  a_reset_position: assert property (p_reset_position) else $error("bad reset position"); // R17

  property p_hold_keeps;
    @(posedge aclk) disable iff (!aresetn) !run_mode && !run_next |=> $stable(pos_reg);
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("position moved in hold"); // R18

  property p_push_clears;
    @(posedge aclk) disable iff (!aresetn)
      push_reg && !pin_edge && !(wr_ctrl && wdata_reg[5]) |=> !push_reg;
  endproperty
  a_push_clears: assert property (p_push_clears) else $error("push bit stuck"); // R12

  property p_step_up;
    @(posedge aclk) disable iff (!aresetn)
      trigger && run_next && eff_dir && sel_mode == 3'h0 |=> pos_reg == $past(pos_reg) + 7'h01;
  endproperty
  a_step_up: assert property (p_step_up) else $error("forward step wrong"); // R8

  property p_step_down;
    @(posedge aclk) disable iff (!aresetn)
      trigger && run_next && !eff_dir && sel_mode == 3'h0 |=> pos_reg == $past(pos_reg) - 7'h01;
  endproperty
  a_step_down: assert property (p_step_down) else $error("backward step wrong"); // R20

  property p_full1_grid;
    @(posedge aclk) disable iff (!aresetn) step_fire && sel_mode == 3'h5 |=> pos_reg[4:0] == 5'h00;
  endproperty
  a_full1_grid: assert property (p_full1_grid) else $error("full step one off grid"); // R1

  property p_full2_grid;
    @(posedge aclk) disable iff (!aresetn) step_fire && sel_mode == 3'h7 |=> pos_reg[4:0] == 5'h10;
  endproperty
  a_full2_grid: assert property (p_full2_grid) else $error("full step two off grid"); // R3

  property p_mode_latched;
    @(posedge aclk) disable iff (!aresetn) !step_fire |=> $stable(applied_mode_reg);
  endproperty
  a_mode_latched: assert property (p_mode_latched) else $error("mode changed without step"); // R15

  property p_two_steps;
    @(posedge aclk) disable iff (!aresetn) pin_edge && push_reg |=> push_reg ##1 !pin_edge;
  endproperty
  a_two_steps: assert property (p_two_steps) else $error("push lost beside pin edge"); // R13

  property p_coarse;
    @(posedge aclk) disable iff (!aresetn) step_fire && sel_mode == 3'h2 |=> pos_reg[1:0] == 2'h0;
  endproperty
  a_coarse: assert property (p_coarse) else $error("eighth step off grid"); // R21
endmodule : stp_top
`default_nettype wire

/* hw/stp_defs.svh */
// Register offsets, field positions, reset values and constants of the stepper positioner.
`ifndef STP_DEFS_SVH
`define STP_DEFS_SVH
`define STP_ADDR_CTRL 8'h00
`define STP_ADDR_CURRENT 8'h04
`define STP_ADDR_STATUS 8'h08
`define STP_ADDR_POSITION 8'h0C
`define STP_ADDR_COIL 8'h10
`define STP_CTRL_DIR_POL 0
`define STP_CTRL_RH_POL 1
`define STP_CTRL_MODE_LSB 2
`define STP_CTRL_MODE_MSB 4
`define STP_CTRL_PUSH 5
`define STP_CTRL_MOTOR_DRIVE_ENABLE 6
`define STP_CTRL_PIN_MODE 7
`define STP_CUR_RUN_LSB 0
`define STP_CUR_RUN_MSB 3
`define STP_CUR_HOLD_LSB 4
`define STP_CUR_HOLD_MSB 7
`define STP_CTRL_RESET 8'h00
`define STP_CUR_RESET 8'h00
`define STP_POS_RESET 7'h10
`define STP_FULL_PITCH 7'h20
`define STP_FULL2_OFFSET 7'h10
`define STP_FULL2_PCT 10'h2C6
`define STP_QUARTER 6'h20
`define STP_RESP_OKAY 2'h0
`define STP_RESP_SLVERR 2'h2
`endif

/* hw/stp_pkg.sv */
// Types shared by the stepper positioner modules.
package stp_pkg;
  typedef logic [6:0] stp_pos_t;
  typedef logic signed [10:0] stp_pct_t;
  typedef enum logic [2:0] {
    STP_MICRO32 = 3'h0,
    STP_MICRO16 = 3'h1,
    STP_MICRO8 = 3'h2,
    STP_MICRO4 = 3'h3,
    STP_HALF = 3'h4,
    STP_FULL1A = 3'h5,
    STP_FULL1B = 3'h6,
    STP_FULL2 = 3'h7
  } stp_mode_e;
endpackage : stp_pkg

/* hw/stp_sync.sv */
// Two flip-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module stp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage, so metastability cannot spread.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : stp_sync
`default_nettype wire

/* hw/stp_coil_map.sv */
// Lookup of the coil current percentages from the translator position.
`timescale 1ns/1ps
`default_nettype none
module stp_coil_map
  import stp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire stp_pos_t position,
  input wire logic full2,
  output stp_pct_t coil_x_pct,
  output stp_pct_t coil_y_pct
);
`include "stp_defs.svh"

  // Quarter sine in tenths of a percent, index 0 to 32.
  function automatic logic [9:0] quarter_sine(input logic [5:0] idx);
    case (idx)
      6'h00: return 10'h000;
      6'h01: return 10'h031;
      6'h02: return 10'h062;
      6'h03: return 10'h093;
      6'h04: return 10'h0C3;
      6'h05: return 10'h0F3;
      6'h06: return 10'h122;
      6'h07: return 10'h151;
      6'h08: return 10'h17F;
      6'h09: return 10'h1AC;
      6'h0A: return 10'h1D7;
      6'h0B: return 10'h202;
      6'h0C: return 10'h22C;
      6'h0D: return 10'h254;
      6'h0E: return 10'h27A;
      6'h0F: return 10'h2A0;
      6'h10: return 10'h2C3;
      6'h11: return 10'h2E5;
      6'h12: return 10'h305;
      6'h13: return 10'h323;
      6'h14: return 10'h33F;
      6'h15: return 10'h35A;
      6'h16: return 10'h372;
      6'h17: return 10'h388;
      6'h18: return 10'h39C;
      6'h19: return 10'h3AE;
      6'h1A: return 10'h3BD;
      6'h1B: return 10'h3CA;
      6'h1C: return 10'h3D5;
      6'h1D: return 10'h3DD;
      6'h1E: return 10'h3E3;
      6'h1F: return 10'h3E7;
      default: return 10'h3E8;
    endcase
  endfunction : quarter_sine

  // Full step two sits on the diagonals only, where both coils carry 71 percent.
  function automatic stp_pct_t signed_sine(input stp_pos_t pos, input logic diag);
    logic [9:0] mag;
    mag = pos[5] ? quarter_sine(6'(`STP_QUARTER - {1'b0, pos[4:0]})) :
                   quarter_sine({1'b0, pos[4:0]});
    if (diag) begin
      mag = `STP_FULL2_PCT; // see R2
    end
    return pos[6] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction : signed_sine

  stp_pos_t cos_pos;
  assign cos_pos = position + `STP_FULL_PITCH;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coil_x_pct <= '0;
      coil_y_pct <= '0;
    end else begin
      coil_x_pct <= signed_sine(cos_pos, full2); // see R2
      coil_y_pct <= signed_sine(position, full2);
    end
  end
endmodule : stp_coil_map
`default_nettype wire

/* tb/stp_ctl_model.sv */
// Behavioural model of the controller that drives the step, direction, run/hold and mode pins.
`timescale 1ns/1ps
`default_nettype none
module stp_ctl_model (
  input wire logic aclk,
  output logic step_trigger_pin,
  output logic direction_pin,
  output logic run_hold_pin,
  output logic mode_pin_low,
  output logic mode_pin_high
);
  initial begin
    step_trigger_pin = 1'b0;
    direction_pin = 1'b0;
    run_hold_pin = 1'b0;
    mode_pin_low = 1'b0;
    mode_pin_high = 1'b0;
  end

  // Level pins move only while the step pin has been low for a while.
  task automatic set_pins(input logic dir, input logic rh, input logic lo, input logic hi);
    repeat (4) @(posedge aclk);
    direction_pin <= dir;
    run_hold_pin <= rh;
    mode_pin_low <= lo;
    mode_pin_high <= hi;
    repeat (4) @(posedge aclk);
  endtask : set_pins

  // A short high time plays a brisk controller, a long one a sluggish one.
  // The low tail keeps any following push clear of this edge.
  task automatic pulse(input int hi_len);
    @(posedge aclk);
    step_trigger_pin <= 1'b1;
    repeat (hi_len) @(posedge aclk);
    step_trigger_pin <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : pulse
endmodule : stp_ctl_model
`default_nettype wire

/* tb/stp_top_tb.sv */
// Self-checking bench for the stepper positioner through its register port and pins.
`timescale 1ns/1ps
`default_nettype none
`include "stp_defs.svh"
module stp_top_tb;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [3:0] wstrb;
  logic [6:0] ex;
  wire logic awready, wready, bvalid, arready, rvalid, motor_drive_enable, run_mode;
  wire logic step_trigger_pin, direction_pin, run_hold_pin, mode_pin_low, mode_pin_high;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [6:0] translator_position;
  wire logic [3:0] current_code;
  wire logic [9:0] current_ma;
  wire logic [10:0] cx, cy;
  int n_mismatch = 0;
  int compares = 0;
  int i;
  localparam logic [9:0] RUNMA [5] = '{10'h03B, 10'h047, 10'h054, 10'h064, 10'h077};
  localparam logic [31:0] FS [8] = '{32'h000003E8, 32'h02C602C6, 32'h03E80000,
    32'h02C6053A, 32'h00000418, 32'h053A053A, 32'h04180000, 32'h053A02C6};

  always #5 aclk = ~aclk;

  stp_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .step_trigger_pin(step_trigger_pin), .direction_pin(direction_pin),
    .run_hold_pin(run_hold_pin), .mode_pin_low(mode_pin_low), .mode_pin_high(mode_pin_high),
    .translator_position(translator_position), .coil_x_pct(cx), .coil_y_pct(cy),
    .current_code(current_code), .current_ma(current_ma),
    .motor_drive_enable(motor_drive_enable), .run_mode(run_mode)
  );

  stp_ctl_model u_ctl (
    .aclk(aclk), .step_trigger_pin(step_trigger_pin), .direction_pin(direction_pin),
    .run_hold_pin(run_hold_pin), .mode_pin_low(mode_pin_low), .mode_pin_high(mode_pin_high)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    compares++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : chk

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic aw_p, w_p;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, `STP_RESP_OKAY, v);
    chk(v, e);
  endtask : rdc

  // Next grid point strictly above or below, on the grid of the given mode.
  function automatic logic [6:0] nxt(input logic [6:0] p, input logic [2:0] m, input logic up);
    logic [6:0] o, s, q;
    o = (m == 3'h7) ? 7'h10 : 7'h00;
    s = (m > 3'h4) ? 7'h20 : (7'h01 << m);
    q = p - o;
    if (up) q = (q & ~(s - 7'h01)) + s;
    else q = (q - 7'h01) & ~(s - 7'h01);
    return q + o;
  endfunction : nxt

  task automatic exp_step(input logic [7:0] c, input int n);
    logic [2:0] m;
    m = c[7] ? {1'b0, mode_pin_high, mode_pin_low} : c[4:2];
    repeat (n) begin
      if (run_hold_pin ^ c[1]) ex = nxt(ex, m, direction_pin ^ c[0]);
    end
    rdc(`STP_ADDR_POSITION, {25'h0, ex});
    chk({25'h0, translator_position}, {25'h0, ex});
  endtask : exp_step

  task automatic pstep(input logic [7:0] c);
    wr(`STP_ADDR_CTRL, {24'h0, c | 8'h20}, `STP_RESP_OKAY);
    exp_step(c, 1);
  endtask : pstep

  // The span is many times the few hundred cycles the sequence needs.
  initial begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    ex = 7'h10;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`STP_ADDR_POSITION, 32'h10);
    rdc(`STP_ADDR_COIL, 32'h02C302C3);
    rdc(`STP_ADDR_CTRL, 32'h0);
    pstep(8'h01);
    rdc(`STP_ADDR_CTRL, 32'h01);
    for (i = 0; i < 5; i++) begin
      pstep({3'h0, 3'(i), 2'h3});
    end
    wr(`STP_ADDR_CTRL, 32'h1F, `STP_RESP_OKAY);
    rdc(`STP_ADDR_POSITION, {25'h0, ex});
    for (i = 0; i < 8; i++) begin
      pstep(i[0] ? 8'h17 : 8'h1F);
      rdc(`STP_ADDR_COIL, FS[ex[6:4]]);
      chk({5'h0, cy, 5'h0, cx}, FS[ex[6:4]]);
    end
    for (i = 0; i < 10; i++) begin
      pstep(i[0] ? 8'h1A : 8'h1E);
      rdc(`STP_ADDR_COIL, FS[ex[6:4]]);
    end
    pstep(8'h02);
    pstep(8'h03);
    pstep(8'h43);
    chk({31'h0, motor_drive_enable}, 32'h1);
    pstep(8'h03);
    chk({31'h0, motor_drive_enable}, 32'h0);
    for (i = 0; i < 5; i++) begin
      wr(`STP_ADDR_CURRENT, {24'h0, 4'(i), 4'(i)}, `STP_RESP_OKAY);
      wr(`STP_ADDR_CTRL, 32'h00, `STP_RESP_OKAY);
      rd(`STP_ADDR_STATUS, `STP_RESP_OKAY, d);
      chk({22'h0, d[25:16]}, {22'h0, (i == 0) ? 10'h000 : RUNMA[i-1]});
      chk({28'h0, current_code}, {28'h0, 4'(i)});
      wr(`STP_ADDR_CTRL, 32'h02, `STP_RESP_OKAY);
      rd(`STP_ADDR_STATUS, `STP_RESP_OKAY, d);
      chk({22'h0, d[25:16]}, {22'h0, RUNMA[i]});
      chk({22'h0, current_ma}, {22'h0, RUNMA[i]});
      chk({31'h0, run_mode}, 32'h1);
    end
    u_ctl.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
    pstep(8'h03);
    u_ctl.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
    rd(`STP_ADDR_STATUS, `STP_RESP_OKAY, d);
    chk({31'h0, d[0]}, 32'h1);
    chk({31'h0, d[3]}, 32'h0);
    pstep(8'h03);
    pstep(8'h02);
    wr(`STP_ADDR_CTRL, 32'h83, `STP_RESP_OKAY);
    u_ctl.set_pins(1'b1, 1'b0, 1'b0, 1'b1);
    rdc(`STP_ADDR_POSITION, {25'h0, ex});
    u_ctl.pulse(3);
    exp_step(8'h83, 1);
    u_ctl.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
    u_ctl.pulse(12);
    exp_step(8'h83, 1);
    u_ctl.pulse(3);
    wr(`STP_ADDR_CTRL, 32'hA3, `STP_RESP_OKAY);
    exp_step(8'h83, 2);
    // Pin edge and push meet in the same cycle here; both must still be stepped.
    fork
      u_ctl.pulse(3);
      wr(`STP_ADDR_CTRL, 32'hA3, `STP_RESP_OKAY);
    join
    exp_step(8'h83, 2);
    wr(8'h14, 32'h3, `STP_RESP_SLVERR);
    rd(8'h14, `STP_RESP_SLVERR, d);
    chk(d, 32'h0);
    wr(`STP_ADDR_POSITION, 32'h55, `STP_RESP_OKAY);
    rdc(`STP_ADDR_POSITION, {25'h0, ex});
    close_out();
  end
endmodule : stp_top_tb
`default_nettype wire
